// *** inc/bacu_map.svh ***
`ifndef BACU_MAP_SVH
`define BACU_MAP_SVH
// op-codes of the block's own instructions
`define BACU_OP4_ADD_SUM 4'h6
`define BACU_OP8_HALF_ADD 8'hF3
`define BACU_OP8_INC 8'h91
`define BACU_OP8_DEC 8'h93
`define BACU_OP8_LIS 8'hA4
`define BACU_OP8_LNK_ABS 8'h8A
`define BACU_OP8_LNK_ABS_X 8'h8B
`define BACU_OP8_LNK_REL 8'h8C
`define BACU_OP8_LNK_REL_X 8'h8D
`define BACU_OP8_LNK_REG 8'hEC
`define BACU_OP8_LNK_REG_X 8'hED
`define BACU_OP8_SET_REL 8'h8E
`define BACU_OP8_SET_REL_X 8'h8F
`define BACU_OP8_CLR_REL 8'h88
`define BACU_OP8_CLR_REL_X 8'h89
`define BACU_OP8_SET_REG 8'hEE
`define BACU_OP8_SET_REG_X 8'hEF
`define BACU_OP8_CLR_REG 8'hE8
`define BACU_OP8_CLR_REG_X 8'hE9
`define BACU_OP5_HOP_CLR 5'h00
`define BACU_OP5_HOP_SET 5'h01
// foreign op-codes that change sequencing
`define BACU_OP8_TRAP_IMM 8'hCC
`define BACU_OP8_TRAP_GE 8'hBD
`define BACU_OP8_TRAP_LT 8'hBE
`define BACU_OP8_LOAD_PS 8'hD0
`define BACU_OP8_SUPER_CALL 8'hC0
`define BACU_OP8_WAIT 8'hF0
// condition status windows, link register, sizes
`define BACU_CS_BRANCH_BASE 16
`define BACU_CS_HOP_BASE 24
`define BACU_LINK_GPR 4'hF
`define BACU_X_EXTRA 32'h0000_0004
`define BACU_LEN_SHORT 32'h0000_0002
`define BACU_LEN_LONG 32'h0000_0004
`define BACU_TGT_MASK 32'h00FF_FFFE
`endif

// *** inc/bacu_pkg.sv ***
package bacu_pkg;
  // one instruction offered by the fetch sequencer
  typedef struct packed {
    logic valid;
    logic [31:0] instr; // first halfword in [31:16]
    logic [31:0] addr;
  } bacu_issue_t;
  // general register write
  typedef struct packed {
    logic valid;
    logic [3:0] idx;
    logic [31:0] data;
  } bacu_wb_t;
  // new fetch address
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } bacu_redir_t;
  typedef enum logic [2:0] {K_NONE, K_SUM, K_HALF, K_INC, K_DEC, K_LIS, K_BR} bacu_kind_t;
  typedef enum logic [1:0] {F_REL20, F_REL8, F_ABS_IMM, F_ABS_REG} bacu_form_t;
  typedef enum logic [1:0] {C_ALWAYS, C_SET, C_CLEAR} bacu_cond_t;
  typedef struct packed {
    bacu_kind_t kind;
    bacu_form_t form;
    bacu_cond_t cond;
    logic is_x;
    logic link;
    logic len4;
  } bacu_dec_t;
  typedef enum {S_IDLE, S_SUBJ} bacu_state_t;
endpackage

// *** core/bacu_core.sv ***
`timescale 1ns/1ps
`include "bacu_map.svh"

// Operation
// - op 6 writes R2 plus 0/R3 into R1
// - halfword add, upper half copied, no carry
// - increment by zero-extended 4-bit immediate
// - decrement by zero-extended 4-bit immediate
// - load register with zero-extended immediate
// - subject always runs; decision precedes its status
// - plain link saves halfword after branch
// - delayed link saves updated address plus four
// - branch selector 0..15 picks status 16..31
// - hop selector 0..7 picks status 24..31
// - relative target is sign-extended offset doubled
// - register forms take 24-bit target
// - 8-bit hop and 20-bit branch offsets
// - no interrupt between branch and subject
// - flow-changing subject raises program check
// - absolute link writes register 15, even target
// - absolute delayed link writes register 15 plus four
// - relative link writes second field register
// - relative delayed link adds four, then branches
// - branches run in every privilege state
// - third field zero supplies constant zero
// - set forms need one, clear forms zero
// - register target least significant bit cleared
module bacu_core
  import bacu_pkg::*;
#(
  parameter int XLEN = 32 // data path width
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire bacu_issue_t iss,
  input wire logic [31:0] r2_data,
  input wire logic [31:0] r3_data,
  input wire logic [31:0] cs_bits,
  output bacu_wb_t wb_q,
  output bacu_redir_t redir_q,
  output logic prog_check_q,
  output logic irq_block_q,
  output logic subject_wait_q
);

  // only a 32-bit data path is built
  if (XLEN != 32)
  begin : g_width_chk
    $error("bacu_core serves XLEN of 32 only");
  end

  // map an op-code onto its attributes
  function automatic bacu_dec_t bacu_decode(input logic [31:0] ins);
    bacu_dec_t d;
    d = '{kind: K_NONE, form: F_REL20, cond: C_ALWAYS, is_x: 1'b0, link: 1'b0, len4: 1'b0};
    case (ins[31:24])
      `BACU_OP8_HALF_ADD: d.kind = K_HALF;
      `BACU_OP8_INC: d.kind = K_INC;
      `BACU_OP8_DEC: d.kind = K_DEC;
      `BACU_OP8_LIS: d.kind = K_LIS;
      `BACU_OP8_LNK_ABS, `BACU_OP8_LNK_ABS_X:
      begin
        d = '{kind: K_BR, form: F_ABS_IMM, cond: C_ALWAYS, is_x: ins[24], link: 1'b1, len4: 1'b1};
      end
      `BACU_OP8_LNK_REL, `BACU_OP8_LNK_REL_X:
      begin
        d = '{kind: K_BR, form: F_REL20, cond: C_ALWAYS, is_x: ins[24], link: 1'b1, len4: 1'b1};
      end
      `BACU_OP8_LNK_REG, `BACU_OP8_LNK_REG_X:
      begin
        d = '{kind: K_BR, form: F_ABS_REG, cond: C_ALWAYS, is_x: ins[24], link: 1'b1, len4: 1'b0};
      end
      `BACU_OP8_SET_REL, `BACU_OP8_SET_REL_X:
      begin
        d = '{kind: K_BR, form: F_REL20, cond: C_SET, is_x: ins[24], link: 1'b0, len4: 1'b1};
      end
      `BACU_OP8_CLR_REL, `BACU_OP8_CLR_REL_X:
      begin
        d = '{kind: K_BR, form: F_REL20, cond: C_CLEAR, is_x: ins[24], link: 1'b0, len4: 1'b1};
      end
      `BACU_OP8_SET_REG, `BACU_OP8_SET_REG_X:
      begin
        d = '{kind: K_BR, form: F_ABS_REG, cond: C_SET, is_x: ins[24], link: 1'b0, len4: 1'b0};
      end
      `BACU_OP8_CLR_REG, `BACU_OP8_CLR_REG_X:
      begin
        d = '{kind: K_BR, form: F_ABS_REG, cond: C_CLEAR, is_x: ins[24], link: 1'b0, len4: 1'b0};
      end
      default:
      begin
        // short formats carry narrower op-codes
        if (ins[31:28] == `BACU_OP4_ADD_SUM)
          d.kind = K_SUM;
        else if (ins[31:27] == `BACU_OP5_HOP_SET)
          d = '{kind: K_BR, form: F_REL8, cond: C_SET, is_x: 1'b0, link: 1'b0, len4: 1'b0};
        else if (ins[31:27] == `BACU_OP5_HOP_CLR)
          d = '{kind: K_BR, form: F_REL8, cond: C_CLEAR, is_x: 1'b0, link: 1'b0, len4: 1'b0};
      end
    endcase
    return d;
  endfunction

  // instructions that may not sit in the delay slot
  function automatic logic bacu_flow_change(input logic [31:0] ins);
    bacu_dec_t d;
    logic [7:0] op;
    d = bacu_decode(ins);
    op = ins[31:24];
    return (d.kind == K_BR) || (op == `BACU_OP8_TRAP_IMM) || (op == `BACU_OP8_TRAP_GE)
      || (op == `BACU_OP8_TRAP_LT) || (op == `BACU_OP8_LOAD_PS)
      || (op == `BACU_OP8_SUPER_CALL) || (op == `BACU_OP8_WAIT);
  endfunction

  // halfword offset doubled onto the branch's own address
  function automatic logic [31:0] bacu_rel(input logic [31:0] base, input logic [19:0] disp);
    return base + {{11{disp[19]}}, disp, 1'b0};
  endfunction

  // condition status bit by its big-endian number
  function automatic logic bacu_cs_pick(input logic [31:0] cs, input logic [4:0] num);
    return cs[5'd31 - num];
  endfunction

  bacu_state_t state_q; // idle or waiting for subject
  logic pend_take_q; // branch decision held over the slot
  logic [31:0] pend_tgt_q; // target held over the slot
  bacu_dec_t dec; // current instruction attributes
  logic [31:0] r3z; // third field operand
  logic cs_bit; // selected condition bit
  logic taken; // branch decision
  logic [31:0] target; // branch target
  logic [31:0] upd; // updated instruction address
  logic [31:0] link_val; // return address
  logic subj_bad; // illegal delay-slot instruction
  bacu_wb_t alu_wb; // arithmetic result
  logic br_go; // a branch accepted out of idle

  always_comb
  begin
    dec = bacu_decode(iss.instr);
    r3z = (iss.instr[19:16] == 4'h0) ? 32'h0000_0000 : r3_data;
    subj_bad = bacu_flow_change(iss.instr);
    br_go = iss.valid && (state_q == S_IDLE) && (dec.kind == K_BR);
  end

  // branch decision from the status as it stands now, before any slot update
  always_comb
  begin
    if (dec.form == F_REL8)
      cs_bit = bacu_cs_pick(cs_bits, 5'(`BACU_CS_HOP_BASE) + {2'b00, iss.instr[26:24]});
    else
      cs_bit = bacu_cs_pick(cs_bits, 5'(`BACU_CS_BRANCH_BASE) + {1'b0, iss.instr[23:20]});
    case (dec.cond)
      C_SET: taken = cs_bit;
      C_CLEAR: taken = !cs_bit;
      default: taken = 1'b1;
    endcase
  end

  // target address per addressing form
  always_comb
  begin
    case (dec.form)
      F_REL8: target = bacu_rel(iss.addr, {{12{iss.instr[23]}}, iss.instr[23:16]});
      F_ABS_IMM: target = iss.instr & `BACU_TGT_MASK;
      F_ABS_REG: target = r3z & `BACU_TGT_MASK;
      default: target = bacu_rel(iss.addr, iss.instr[19:0]);
    endcase
  end

  // return address
  always_comb
  begin
    upd = iss.addr + (dec.len4 ? `BACU_LEN_LONG : `BACU_LEN_SHORT);
    link_val = dec.is_x ? upd + `BACU_X_EXTRA : upd;
  end

  // arithmetic group, no condition status touched
  always_comb
  begin
    alu_wb = '{valid: 1'b1, idx: iss.instr[23:20], data: 32'h0000_0000};
    case (dec.kind)
      K_SUM:
      begin
        alu_wb.idx = iss.instr[27:24];
        alu_wb.data = r2_data + r3z;
      end
      K_HALF: alu_wb.data = {r3z[31:16], r2_data[15:0] + r3z[15:0]};
      K_INC: alu_wb.data = r2_data + {28'h0000000, iss.instr[19:16]};
      K_DEC: alu_wb.data = r2_data - {28'h0000000, iss.instr[19:16]};
      K_LIS: alu_wb.data = {28'h0000000, iss.instr[19:16]};
      default: alu_wb.valid = 1'b0;
    endcase
  end

  // slot sequencer; no privilege input exists, branches never fault on it
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      state_q <= S_IDLE;
    else if (br_go && dec.is_x)
      state_q <= S_SUBJ;
    else if (iss.valid)
      state_q <= S_IDLE;
  end

  // held decision and target, taken at the branch itself
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      pend_take_q <= 1'b0;
      pend_tgt_q <= 32'h0000_0000;
    end
    else if (br_go)
    begin
      pend_take_q <= taken;
      pend_tgt_q <= target;
    end
  end

  // fetch redirect; a delayed branch waits for its subject
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      redir_q <= '{valid: 1'b0, addr: 32'h0000_0000};
    else if (br_go && !dec.is_x)
      redir_q <= '{valid: taken, addr: target};
    else if (iss.valid && (state_q == S_SUBJ) && !subj_bad)
      redir_q <= '{valid: pend_take_q, addr: pend_tgt_q};
    else
      redir_q.valid <= 1'b0;
  end

  // register writes: link at the branch, arithmetic also in the slot
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      wb_q <= '{valid: 1'b0, idx: 4'h0, data: 32'h0000_0000};
    else if (br_go && dec.link)
      wb_q <= '{valid: 1'b1, idx: (dec.form == F_ABS_IMM) ? `BACU_LINK_GPR : iss.instr[23:20],
                data: link_val};
    else if (iss.valid && !(state_q == S_SUBJ && subj_bad))
      wb_q <= alu_wb;
    else
      wb_q.valid <= 1'b0;
  end

  // one-cycle program check for a bad subject
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      prog_check_q <= 1'b0;
    else
      prog_check_q <= iss.valid && (state_q == S_SUBJ) && subj_bad;
  end

  // interrupts held off while the pair is open
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_block_q <= 1'b0;
      subject_wait_q <= 1'b0;
    end
    else
    begin
      irq_block_q <= (br_go && dec.is_x) || (state_q == S_SUBJ && !iss.valid);
      subject_wait_q <= (br_go && dec.is_x) || (state_q == S_SUBJ && !iss.valid);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_xbranch;
    br_go && dec.is_x && taken;
  endsequence
  sequence s_good_subject;
    iss.valid && !subj_bad;
  endsequence

  sum_write_a: assert property (iss.valid && state_q == S_IDLE && dec.kind == K_SUM
    |=> wb_q.valid && wb_q.data == $past(r2_data) + $past(r3z))
    else $error("address sum result wrong");
  dec_write_a: assert property (iss.valid && state_q == S_IDLE && dec.kind == K_DEC
    |=> wb_q.data == $past(r2_data) - {28'h0000000, $past(iss.instr[19:16])})
    else $error("decrement result wrong");
  lis_write_a: assert property (iss.valid && state_q == S_IDLE && dec.kind == K_LIS
    |=> wb_q.valid && wb_q.data[31:4] == 28'h0000000)
    else $error("small immediate not zero-extended");
  slot_redirect_a: assert property (s_xbranch ##1 s_good_subject |=> redir_q.valid)
    else $error("delayed branch did not redirect after subject");
  no_early_a: assert property (s_xbranch |=> !redir_q.valid)
    else $error("delayed branch redirected before subject");
  irq_hold_a: assert property (br_go && dec.is_x |=> irq_block_q)
    else $error("interrupts not held after delayed branch");
  bad_subject_a: assert property (iss.valid && state_q == S_SUBJ && subj_bad
    |=> prog_check_q && !redir_q.valid)
    else $error("illegal subject not flagged");
  link_plus4_a: assert property (br_go && dec.link && dec.is_x
    |=> wb_q.valid && wb_q.data == $past(upd) + `BACU_X_EXTRA)
    else $error("delayed link address wrong");
  even_target_a: assert property (redir_q.valid |-> !redir_q.addr[0])
    else $error("odd fetch target");

endmodule // bacu_core

// *** tb/bacu_gr_model.sv ***
`timescale 1ns/1ps
// general registers seen by the block: operand read-out and write-back
module bacu_gr_model
  import bacu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire bacu_issue_t iss,
  input wire bacu_wb_t wb_q,
  output logic [31:0] r2_data,
  output logic [31:0] r3_data
);
  logic [31:0] gr [16]; // register contents
  // seeds whose low halves overflow when added, so a stray carry shows
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      for (int k = 0; k < 16; k++)
        gr[k] <= {4'(k), 12'h0A5, 16'hFFF0 + 16'(k)};
    end
    else if (wb_q.valid)
      gr[wb_q.idx] <= wb_q.data;
  // no operand outside an issue cycle: lines invert rather than hold
  assign r2_data = iss.valid ? gr[iss.instr[23:20]] : ~gr[iss.instr[23:20]];
  assign r3_data = iss.valid ? gr[iss.instr[19:16]] : ~gr[iss.instr[19:16]];
endmodule // bacu_gr_model

// *** tb/tb_branch_and_address_compute_unit.sv ***
`timescale 1ns/1ps
`include "bacu_map.svh"
module tb_branch_and_address_compute_unit
  import bacu_pkg::*;
;
  logic clk_sys = 1'b0; // 40 MHz
  logic resetn = 1'b0; // active low
  bacu_issue_t iss = '0; // instruction offered
  logic [31:0] cs_bits = 32'h0; // condition status
  logic [31:0] r2_data;
  logic [31:0] r3_data;
  bacu_wb_t wb_q;
  bacu_redir_t redir_q;
  logic prog_check_q;
  logic irq_block_q;
  logic subject_wait_q;
  int err_count = 0;
  int n_tests = 0;
  // illegal subjects: branches, hop, traps, status load, call, wait
  logic [7:0] ill [10] = '{8'h8E, 8'h8A, 8'hEC, 8'h08, 8'hCC, 8'hBD, 8'hBE, 8'hD0, 8'hC0, 8'hF0};
  always #12.5 clk_sys = ~clk_sys;
  bacu_core u_dut (.clk_sys(clk_sys), .resetn(resetn), .iss(iss), .r2_data(r2_data), .r3_data(r3_data),
    .cs_bits(cs_bits), .wb_q(wb_q), .redir_q(redir_q), .prog_check_q(prog_check_q),
    .irq_block_q(irq_block_q), .subject_wait_q(subject_wait_q));
  bacu_gr_model u_gr (.clk_sys(clk_sys), .resetn(resetn), .iss(iss), .wb_q(wb_q), .r2_data(r2_data),
    .r3_data(r3_data));
  // compare and count
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // offer one instruction; returns just after the edge that answers it
  task automatic step(input logic v, input logic [31:0] ins, input logic [31:0] a);
    iss <= '{valid: v, instr: ins, addr: a};
    @(posedge clk_sys);
    #1;
  endtask
  // register-writing operation
  task automatic op_wb(input logic [31:0] ins, input logic [3:0] i, input logic [31:0] d);
    step(1'b1, ins, 32'h0000_0200);
    chk({wb_q.valid, wb_q.idx, wb_q.data}, {1'b1, i, d});
  endtask
  // plain conditional branch, taken or not
  task automatic br(input logic [31:0] ins, a, cs, input logic tk, input logic [31:0] t);
    cs_bits <= cs;
    step(1'b1, ins, a);
    chk(redir_q.valid, tk);
    if (tk)
      chk(redir_q.addr, t);
  endtask
  // plain link: link write and redirect in the same answer
  task automatic lnk(input logic [31:0] ins, a, input logic [3:0] i, input logic [31:0] ra, t);
    step(1'b1, ins, a);
    chk({wb_q.valid, wb_q.idx, wb_q.data}, {1'b1, i, ra});
    chk({redir_q.valid, redir_q.addr}, {1'b1, t});
  endtask
  // delayed branch plus a short load as subject; status flips under the subject
  task automatic dly(input logic [31:0] bi, a, c0, c1, input logic lk, tk, input logic [3:0] i,
    input logic [31:0] ra, t);
    cs_bits <= c0;
    step(1'b1, bi, a);
    chk({irq_block_q, subject_wait_q, redir_q.valid}, 3'b110);
    if (lk)
      chk({wb_q.valid, wb_q.idx, wb_q.data}, {1'b1, i, ra});
    cs_bits <= c1;
    step(1'b1, {8'hA4, 4'hC, 4'h5, 16'h0}, a + 32'h4); // subject never reads the pointer
    chk({irq_block_q, redir_q.valid, wb_q.valid, wb_q.idx, wb_q.data}, {1'b0, tk, 1'b1, 4'hC, 32'h5});
    if (tk)
      chk(redir_q.addr, t);
  endtask
  task automatic t_alu;
    op_wb({4'h6, 4'h4, 4'h2, 4'h3, 16'h0}, 4'h4, u_gr.gr[2] + u_gr.gr[3]);
    op_wb({4'h6, 4'h5, 4'h2, 4'h0, 16'h0}, 4'h5, u_gr.gr[2]);
    op_wb({8'hF3, 4'h6, 4'h8, 16'h0}, 4'h6,
      {u_gr.gr[8][31:16], u_gr.gr[6][15:0] + u_gr.gr[8][15:0]});
    op_wb({8'h91, 4'h7, 4'hF, 16'h0}, 4'h7, u_gr.gr[7] + 32'hF);
    op_wb({8'h93, 4'h9, 4'hF, 16'h0}, 4'h9, u_gr.gr[9] - 32'hF);
    op_wb({8'hA4, 4'hA, 4'hE, 16'h0}, 4'hA, 32'h0000_000E);
    $display("alu done");
  endtask
  // selectors kept to status 24..31; 16..23 are reserved
  task automatic t_branch;
    br({8'h8E, 4'hF, 20'hFFFFE}, 32'h1000, 32'h1, 1'b1, 32'h0FFC);
    br({8'h8E, 4'hF, 20'hFFFFE}, 32'h1000, 32'h0, 1'b0, 32'h0);
    br({8'h88, 4'h8, 20'h7FFFF}, 32'h2000, 32'hFFFF_FF7F, 1'b1, 32'h0010_1FFE);
    br({8'hEE, 4'h9, 4'hB, 16'h0}, 32'h40, 32'h40, 1'b1, u_gr.gr[11] & 32'h00FF_FFFE);
    br({8'hE8, 4'hA, 4'hB, 16'h0}, 32'h40, 32'h20, 1'b0, 32'h0);
    br({5'h01, 3'h7, 8'h80, 16'h0}, 32'h3000, 32'h1, 1'b1, 32'h2F00);
    br({5'h00, 3'h0, 8'h7F, 16'h0}, 32'h3000, 32'h0, 1'b1, 32'h30FE);
    br({5'h01, 3'h7, 8'h80, 16'h0}, 32'h3000, 32'h0, 1'b0, 32'h0);
    $display("branch done");
  endtask
  task automatic t_link;
    lnk({8'h8A, 24'h12_3457}, 32'h400, 4'hF, 32'h404, 32'h0012_3456);
    lnk({8'h8C, 4'h3, 20'h00010}, 32'h800, 4'h3, 32'h804, 32'h820);
    lnk({8'hEC, 4'h4, 4'hB, 16'h0}, 32'h900, 4'h4, 32'h902, u_gr.gr[11] & 32'h00FF_FFFE);
    $display("link done");
  endtask
  task automatic t_delay;
    dly({8'h8B, 24'h00_2001}, 32'h600, 32'h0, 32'h0, 1'b1, 1'b1, 4'hF, 32'h608, 32'h2000);
    dly({8'h8D, 4'h2, 20'h00008}, 32'h700, 32'h0, 32'h0, 1'b1, 1'b1, 4'h2, 32'h708, 32'h710);
    dly({8'h8F, 4'hF, 20'h00004}, 32'h300, 32'h1, 32'h0, 1'b0, 1'b1, 4'h0, 32'h0, 32'h308);
    dly({8'h89, 4'h8, 20'h00004}, 32'h300, 32'h80, 32'h0, 1'b0, 1'b0, 4'h0, 32'h0, 32'h0);
    dly({8'hED, 4'h1, 4'hB, 16'h0}, 32'h500, 32'h0, 32'h0, 1'b1, 1'b1, 4'h1, 32'h506,
      u_gr.gr[11] & 32'h00FF_FFFE);
    // delayed register forms with a condition, one through a zero third field
    dly({8'hEF, 4'h8, 4'hB, 16'h0}, 32'h500, 32'h80, 32'h0, 1'b0, 1'b1, 4'h0, 32'h0,
      u_gr.gr[11] & 32'h00FF_FFFE);
    dly({8'hE9, 4'h9, 4'h0, 16'h0}, 32'h500, 32'h0, 32'h40, 1'b0, 1'b1, 4'h0, 32'h0, 32'h0);
    // idle gap before the subject: interrupts stay held, no early redirect
    cs_bits <= 32'h1;
    step(1'b1, {8'h8F, 4'hF, 20'h00004}, 32'h300);
    step(1'b0, 32'hFFFF_FFFF, 32'h0);
    chk({irq_block_q, subject_wait_q, redir_q.valid}, 3'b110);
    step(1'b1, {8'hA4, 4'hC, 4'h5, 16'h0}, 32'h304);
    chk({irq_block_q, redir_q.valid, redir_q.addr}, {1'b0, 1'b1, 32'h308});
    $display("delay done");
  endtask
  // taken delayed branch with a sequencing instruction as its subject
  task automatic t_illegal;
    for (int k = 0; k < 10; k++)
    begin
      cs_bits <= 32'h1;
      step(1'b1, {8'h8F, 4'hF, 20'h00004}, 32'h300);
      step(1'b1, {ill[k], 24'h0}, 32'h304);
      chk({prog_check_q, redir_q.valid, wb_q.valid, irq_block_q}, 4'b1000);
    end
    step(1'b0, 32'hFFFF_FFFF, 32'h0);
    chk(prog_check_q, 1'b0);
    $display("illegal done");
  endtask
  // reset in mid-pair must drop the pending slot, so the next branch is no subject
  task automatic t_reset;
    cs_bits <= 32'h1;
    step(1'b1, {8'h8F, 4'hF, 20'h00004}, 32'h300);
    resetn = 1'b0;
    step(1'b0, 32'hFFFF_FFFF, 32'h0);
    chk({wb_q.valid, redir_q.valid, prog_check_q, irq_block_q, subject_wait_q}, 5'b00000);
    resetn = 1'b1;
    step(1'b1, {8'h8E, 4'hF, 20'h00004}, 32'h300);
    chk({prog_check_q, redir_q.valid, redir_q.addr}, {1'b0, 1'b1, 32'h308});
    $display("reset done");
  endtask
  // verdict and end of run
  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hang guard at 80000 cycles, far beyond the length of the run
  initial
  begin
    #2_000_000;
    err_count++;
    end_sim();
  end
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    chk({wb_q.valid, redir_q.valid, prog_check_q, irq_block_q}, 4'b0000);
    t_alu();
    t_branch();
    t_link();
    t_delay();
    t_illegal();
    t_reset();
    end_sim();
  end
endmodule // tb_branch_and_address_compute_unit
